// file: src/hlf_pkg.sv
// Package of the host link FIFO manager: register offsets, reset values,
// field positions and the structs that carry the CPU register port and the
// host receive push.
// Assumes one 25 MHz clock and a CPU that reaches the registers by address.
package hlf_pkg;

  // Register addresses on the CPU register port.
  localparam logic [7:0] HLF_ADDR_RX_THRESHOLD = 8'h9A;
  localparam logic [7:0] HLF_ADDR_TX_THRESHOLD = 8'h9B;
  localparam logic [7:0] HLF_ADDR_TX_FREE_SPACE = 8'h9C;
  localparam logic [7:0] HLF_ADDR_RX_FILL_COUNT = 8'h9D;
  localparam logic [7:0] HLF_ADDR_QUEUE_STATUS = 8'h9E;
  localparam logic [7:0] HLF_ADDR_IRQ_SOURCE = 8'h9F;
  localparam logic [7:0] HLF_ADDR_IRQ_ENABLE_FLUSH = 8'hA1;
  localparam logic [7:0] HLF_ADDR_DATA_PORT = 8'hA2;
  localparam logic [7:0] HLF_ADDR_RX_PARTITION_SIZE = 8'hA3;

  // Values after reset.
  localparam logic [7:0] HLF_RST_THRESHOLD = 8'h00;
  localparam logic [7:0] HLF_RST_PARTITION = 8'h80;
  localparam logic [7:0] HLF_RST_IRQ_ENABLE = 8'h00;
  localparam logic [5:0] HLF_RST_IRQ_SOURCE = 6'h00;
  localparam logic [7:0] HLF_RST_BYTE = 8'h00;

  // Highest RAM address; the transmit part is this minus the receive share.
  localparam logic [7:0] HLF_RAM_TOP = 8'hFF;

  // Field positions in the status, source and enable registers.
  localparam int HLF_ST_ENABLE = 7;
  localparam int HLF_SRC_CLEAR = 7;
  localparam int HLF_SRC_WCOL = 5;
  localparam int HLF_SRC_TX_LOW = 4;
  localparam int HLF_SRC_TX_FULL = 3;
  localparam int HLF_SRC_RX_HIGH = 2;
  localparam int HLF_SRC_OVERRUN = 1;
  localparam int HLF_SRC_RX_FULL = 0;
  localparam int HLF_EN_TX_FLUSH = 7;
  localparam int HLF_EN_RX_FLUSH = 6;

  // CPU register port request.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hlf_sfr_req_t;

  // Host receive push: a level request with the byte it carries.
  typedef struct packed {
    logic       request;
    logic [7:0] data;
  } hlf_rx_push_t;

  // Whole state of the manager.
  typedef struct packed {
    logic [7:0] rx_thr;
    logic [7:0] tx_thr;
    logic [7:0] rx_size;
    logic       enable;
    logic [5:0] src;
    logic [7:0] ien;
    logic [7:0] rx_wr;
    logic [7:0] rx_rd;
    logic [7:0] rx_cnt;
    logic [7:0] tx_wr;
    logic [7:0] tx_rd;
    logic [7:0] tx_cnt;
    logic [7:0] rdata;
    logic       rd_sel;
    logic       rd_hit;
    logic       tx_valid;
  } hlf_state_t;

endpackage

// file: src/hlf_ram.sv
// Shared byte RAM of the FIFO manager: one write port, one read port whose
// data come out of a register.
// Assumes the caller never reads and writes ports beyond its own arbitration.
`timescale 1ns/1ps
module hlf_ram
  import hlf_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_en,
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data
);

  logic [7:0] mem [0:255];

  // The array keeps no reset, so it maps onto plain RAM cells.
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data are registered and hold until the next read.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_data <= HLF_RST_BYTE;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// file: src/hlf_fifo_mgr.sv
// Host link FIFO manager: runs one shared RAM as a receive FIFO and a
// transmit FIFO between the CPU register port and the host interface logic.
// Assumes single-cycle CPU strobes and host requests held until granted.
`timescale 1ns/1ps
module hlf_fifo_mgr
  import hlf_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire hlf_sfr_req_t sfr_req,
  output logic        [7:0] sfr_rdata,
  input  wire logic         iface_tx_request,
  output logic              iface_tx_grant,
  output logic              iface_tx_valid,
  output logic        [7:0] iface_tx_data,
  input  wire hlf_rx_push_t iface_rx_request,
  output logic              iface_rx_grant,
  output logic              fifo_irq,
  output logic              fifo_clk_en
);

  // Advances a pointer inside a region of the given size, wrapping to zero.
  function automatic logic [7:0] wrap_inc(input logic [7:0] p,
                                          input logic [7:0] size);
    logic [7:0] n;
    n = p + 8'h01;
    if (n >= size) begin
      n = 8'h00;
    end
    return n;
  endfunction

  // Places a transmit offset above the receive share of the RAM.
  function automatic logic [7:0] tx_addr(input logic [7:0] base,
                                         input logic [7:0] p);
    return base + p;
  endfunction

  hlf_state_t st_r;
  hlf_state_t st_nxt;

  logic       cpu_wr_data;
  logic       cpu_rd_data;
  logic       cpu_wr_reg;
  logic [7:0] tx_size;
  logic       tx_low;
  logic       tx_full;
  logic       tx_empty;
  logic       rx_high;
  logic       rx_full;
  logic       rx_empty;
  logic       flush_tx;
  logic       flush_rx;
  logic       tx_push;
  logic       wcol;
  logic       rx_pop;
  logic       tx_pop;
  logic       rx_take;
  logic       rx_store;
  logic       overrun;
  logic [7:0] status;
  logic [5:0] hw_set;
  logic       ram_wr_en;
  logic [7:0] ram_wr_addr;
  logic [7:0] ram_wr_data;
  logic       ram_rd_en;
  logic [7:0] ram_rd_addr;
  logic [7:0] ram_q;

  // Data port decode and a strobe for every other register write.
  assign cpu_wr_data = sfr_req.wr && (sfr_req.addr == HLF_ADDR_DATA_PORT);
  assign cpu_rd_data = sfr_req.rd && (sfr_req.addr == HLF_ADDR_DATA_PORT);
  assign cpu_wr_reg = sfr_req.wr && !cpu_wr_data;

  // The transmit part gets the highest RAM address minus the receive share, one byte less than the rest.
  assign tx_size = HLF_RAM_TOP - st_r.rx_size;

  // Flags follow the counters directly, so they move with each push or pop.
  assign tx_low = st_r.tx_cnt <= st_r.tx_thr;
  assign tx_full = st_r.tx_cnt == tx_size;
  assign tx_empty = st_r.tx_cnt == 8'h00;
  assign rx_high = (st_r.rx_cnt >= st_r.rx_thr) && !rx_empty;
  assign rx_full = st_r.rx_cnt == st_r.rx_size;
  assign rx_empty = st_r.rx_cnt == 8'h00;

  // Flush controls are levels that hold their pointers at zero.
  assign flush_tx = st_r.ien[HLF_EN_TX_FLUSH];
  assign flush_rx = st_r.ien[HLF_EN_RX_FLUSH];

  // A cleared enable stops every FIFO move and hardware source set; register reads, writes and flushes still act.
  assign fifo_clk_en = st_r.enable;

  // CPU data port moves; a write into a full transmit part is dropped.
  assign tx_push = st_r.enable && cpu_wr_data && !tx_full && !flush_tx;
  assign wcol = st_r.enable && cpu_wr_data && tx_full;
  assign rx_pop = st_r.enable && cpu_rd_data && !rx_empty && !flush_rx;

  // The CPU owns a RAM port in its cycle; the host waits and is granted later.
  assign tx_pop = st_r.enable && iface_tx_request && !tx_empty && !rx_pop && !flush_tx;
  assign rx_take = st_r.enable && iface_rx_request.request && !tx_push && !flush_rx;

  // A completed receive into a full part is taken but thrown away.
  assign rx_store = rx_take && !rx_full;
  assign overrun = rx_take && rx_full;

  assign iface_tx_grant = tx_pop;
  assign iface_rx_grant = rx_take;

  // Status byte; bit 6 reads as zero.
  assign status = {st_r.enable, 1'b0, tx_low, tx_full, tx_empty,
                   rx_high, rx_full, rx_empty};

  // Hardware sets of the interrupt sources.
  always_comb begin
    hw_set = 6'h00;
    hw_set[HLF_SRC_WCOL] = wcol;
    hw_set[HLF_SRC_TX_LOW] = st_r.enable && tx_low;
    hw_set[HLF_SRC_TX_FULL] = st_r.enable && tx_full;
    hw_set[HLF_SRC_RX_HIGH] = st_r.enable && rx_high;
    hw_set[HLF_SRC_OVERRUN] = overrun;
    hw_set[HLF_SRC_RX_FULL] = st_r.enable && rx_full;
  end

  // RAM ports: the CPU push wins the write port, the CPU pop the read port.
  always_comb begin
    ram_wr_en = tx_push || rx_store;
    ram_wr_addr = st_r.rx_wr;
    ram_wr_data = iface_rx_request.data;
    if (tx_push) begin
      ram_wr_addr = tx_addr(st_r.rx_size, st_r.tx_wr);
      ram_wr_data = sfr_req.wdata;
    end
    ram_rd_en = rx_pop || tx_pop;
    ram_rd_addr = tx_addr(st_r.rx_size, st_r.tx_rd);
    if (rx_pop) begin
      ram_rd_addr = st_r.rx_rd;
    end
  end

  // Next state of the whole manager.
  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_sel = cpu_rd_data;
    st_nxt.rd_hit = rx_pop;
    st_nxt.tx_valid = tx_pop;

    // Register reads other than the data port answer from this copy.
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        HLF_ADDR_RX_THRESHOLD: begin
          st_nxt.rdata = st_r.rx_thr;
        end
        HLF_ADDR_TX_THRESHOLD: begin
          st_nxt.rdata = st_r.tx_thr;
        end
        HLF_ADDR_TX_FREE_SPACE: begin
          st_nxt.rdata = tx_size - st_r.tx_cnt;
        end
        HLF_ADDR_RX_FILL_COUNT: begin
          st_nxt.rdata = st_r.rx_cnt;
        end
        HLF_ADDR_QUEUE_STATUS: begin
          st_nxt.rdata = status;
        end
        HLF_ADDR_IRQ_SOURCE: begin
          st_nxt.rdata = {2'b00, st_r.src};
        end
        HLF_ADDR_IRQ_ENABLE_FLUSH: begin
          st_nxt.rdata = st_r.ien;
        end
        HLF_ADDR_RX_PARTITION_SIZE: begin
          st_nxt.rdata = st_r.rx_size;
        end
        default: begin
          st_nxt.rdata = HLF_RST_BYTE;
        end
      endcase
    end

    // Register writes; the counters ignore writes, they belong to hardware.
    if (cpu_wr_reg) begin
      case (sfr_req.addr)
        HLF_ADDR_RX_THRESHOLD: begin
          st_nxt.rx_thr = sfr_req.wdata;
        end
        HLF_ADDR_TX_THRESHOLD: begin
          st_nxt.tx_thr = sfr_req.wdata;
        end
        HLF_ADDR_QUEUE_STATUS: begin
          st_nxt.enable = sfr_req.wdata[HLF_ST_ENABLE];
        end
        HLF_ADDR_IRQ_SOURCE: begin
          // Bit 7 high clears the marked sources, low sets them.
          if (sfr_req.wdata[HLF_SRC_CLEAR]) begin
            st_nxt.src = st_r.src & ~sfr_req.wdata[5:0];
          end else begin
            st_nxt.src = st_r.src | sfr_req.wdata[5:0];
          end
        end
        HLF_ADDR_IRQ_ENABLE_FLUSH: begin
          st_nxt.ien = sfr_req.wdata;
        end
        HLF_ADDR_RX_PARTITION_SIZE: begin
          st_nxt.rx_size = sfr_req.wdata;
        end
        default: begin
          st_nxt.ien = st_nxt.ien;
        end
      endcase
    end

    // Hardware sets come last so an event in a clearing cycle survives.
    st_nxt.src = st_nxt.src | hw_set;

    // Transmit pointers and count.
    if (tx_push) begin
      st_nxt.tx_wr = wrap_inc(st_r.tx_wr, tx_size);
    end
    if (tx_pop) begin
      st_nxt.tx_rd = wrap_inc(st_r.tx_rd, tx_size);
    end
    if (tx_push && !tx_pop) begin
      st_nxt.tx_cnt = st_r.tx_cnt + 8'h01;
    end else if (tx_pop && !tx_push) begin
      st_nxt.tx_cnt = st_r.tx_cnt - 8'h01;
    end

    // Receive pointers and count.
    if (rx_store) begin
      st_nxt.rx_wr = wrap_inc(st_r.rx_wr, st_r.rx_size);
    end
    if (rx_pop) begin
      st_nxt.rx_rd = wrap_inc(st_r.rx_rd, st_r.rx_size);
    end
    if (rx_store && !rx_pop) begin
      st_nxt.rx_cnt = st_r.rx_cnt + 8'h01;
    end else if (rx_pop && !rx_store) begin
      st_nxt.rx_cnt = st_r.rx_cnt - 8'h01;
    end

    // A held flush keeps its own part empty; the other part is untouched.
    if (flush_tx) begin
      st_nxt.tx_wr = 8'h00;
      st_nxt.tx_rd = 8'h00;
      st_nxt.tx_cnt = 8'h00;
    end
    if (flush_rx) begin
      st_nxt.rx_wr = 8'h00;
      st_nxt.rx_rd = 8'h00;
      st_nxt.rx_cnt = 8'h00;
    end
  end

  // State register with synchronous reset to the documented values.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_r.rx_thr <= HLF_RST_THRESHOLD;
      st_r.tx_thr <= HLF_RST_THRESHOLD;
      st_r.rx_size <= HLF_RST_PARTITION;
      st_r.enable <= 1'b0;
      st_r.src <= HLF_RST_IRQ_SOURCE;
      st_r.ien <= HLF_RST_IRQ_ENABLE;
      st_r.rx_wr <= 8'h00;
      st_r.rx_rd <= 8'h00;
      st_r.rx_cnt <= 8'h00;
      st_r.tx_wr <= 8'h00;
      st_r.tx_rd <= 8'h00;
      st_r.tx_cnt <= 8'h00;
      st_r.rdata <= HLF_RST_BYTE;
      st_r.rd_sel <= 1'b0;
      st_r.rd_hit <= 1'b0;
      st_r.tx_valid <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Shared byte RAM.
  hlf_ram u_ram (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .wr_en   (ram_wr_en),
    .wr_addr (ram_wr_addr),
    .wr_data (ram_wr_data),
    .rd_en   (ram_rd_en),
    .rd_addr (ram_rd_addr),
    .rd_data (ram_q)
  );

  // A data port read answers from the RAM register, zero when nothing was held.
  always_comb begin
    sfr_rdata = st_r.rdata;
    if (st_r.rd_sel) begin
      sfr_rdata = st_r.rd_hit ? ram_q : HLF_RST_BYTE;
    end
  end

  // Host transmit byte leaves the RAM register one cycle after its grant.
  assign iface_tx_valid = st_r.tx_valid;
  assign iface_tx_data = ram_q;

  // Enabled sources are ORed into one request.
  assign fifo_irq = |(st_r.src & st_r.ien[5:0]);

endmodule

// file: sim/hlf_fifo_mgr_asserts.sv
// Checker of the FIFO manager, bound to the top module's ports.
// Assumes the one clock ref_clk and the synchronous active-low rst_b.
`timescale 1ns/1ps
module hlf_fifo_mgr_asserts
  import hlf_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         rst_b,
  input wire hlf_sfr_req_t sfr_req,
  input wire logic   [7:0] sfr_rdata,
  input wire logic         iface_tx_request,
  input wire logic         iface_tx_grant,
  input wire logic         iface_tx_valid,
  input wire logic   [7:0] iface_tx_data,
  input wire hlf_rx_push_t iface_rx_request,
  input wire logic         iface_rx_grant,
  input wire logic         fifo_irq,
  input wire logic         fifo_clk_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Write of the receive threshold, then its read two cycles on.
  sequence s_thr_wr;
    sfr_req.wr && sfr_req.addr == HLF_ADDR_RX_THRESHOLD;
  endsequence
  sequence s_thr_rd;
    sfr_req.rd && sfr_req.addr == HLF_ADDR_RX_THRESHOLD;
  endsequence

  a_reset_quiet: assert property ($rose(rst_b) |-> !fifo_clk_en && !fifo_irq && sfr_rdata == 8'h00)
    else $error("outputs not cleared by reset");
  a_thr_back: assert property (s_thr_wr ##2 s_thr_rd |=> sfr_rdata == $past(sfr_req.wdata, 3))
    else $error("threshold read differs from write");
  a_enable_bit: assert property (sfr_req.wr && sfr_req.addr == HLF_ADDR_QUEUE_STATUS
    |=> fifo_clk_en == $past(sfr_req.wdata[7])) else $error("enable bit not taken");
  a_flush_stall: assert property (sfr_req.wr && sfr_req.addr == HLF_ADDR_IRQ_ENABLE_FLUSH
    && sfr_req.wdata[7] |=> !iface_tx_grant) else $error("grant during transmit flush");
  a_irq_masked: assert property (sfr_req.wr && sfr_req.addr == HLF_ADDR_IRQ_ENABLE_FLUSH
    && sfr_req.wdata[5:0] == 6'h00 |=> !fifo_irq) else $error("interrupt with all sources masked");
  a_tx_valid_next: assert property (iface_tx_grant |=> iface_tx_valid)
    else $error("granted byte not delivered");
  a_tx_valid_cause: assert property (iface_tx_valid |-> $past(iface_tx_grant))
    else $error("transmit valid without grant");
  a_tx_grant_cause: assert property (iface_tx_grant |-> iface_tx_request && fifo_clk_en)
    else $error("transmit grant without request or enable");
  a_rx_grant_cause: assert property (iface_rx_grant |-> iface_rx_request.request && fifo_clk_en)
    else $error("receive grant without request or enable");
endmodule

// file: sim/hlf_host_model.sv
// Host interface side: pushes received bytes and pulls transmit bytes.
// Assumes the bench calls send and drives drain just after a clock edge.
`timescale 1ns/1ps
module hlf_host_model
  import hlf_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         drain,
  output logic             iface_tx_request,
  input wire logic         iface_tx_grant,
  input wire logic         iface_tx_valid,
  input wire logic   [7:0] iface_tx_data,
  output hlf_rx_push_t     iface_rx_request,
  input wire logic         iface_rx_grant
);
  logic [7:0] got_q[$];

  // The transmit request is a level held while the bench wants bytes.
  assign iface_tx_request = drain;
  initial iface_rx_request = '{request: 1'b0, data: 8'hFF};

  // Collects each delivered transmit byte in its valid cycle.
  always @(posedge ref_clk) begin
    if (iface_tx_valid)
      got_q.push_back(iface_tx_data);
  end

  // Holds one completed byte until granted, then shows its inverse.
  task automatic send(input logic [7:0] b);
    @(posedge ref_clk);
    #1 iface_rx_request = '{request: 1'b1, data: b};
    do @(negedge ref_clk); while (iface_rx_grant !== 1'b1);
    @(posedge ref_clk);
    #1 iface_rx_request = '{request: 1'b0, data: ~b};
  endtask
endmodule

// file: sim/tb_hlf_fifo_mgr.sv
// Directed bench of the FIFO manager through its register port.
// Assumes the host model on the far side and the bound checker.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb_hlf_fifo_mgr
  import hlf_pkg::*;
;
  logic         ref_clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         drain = 1'b0;
  hlf_sfr_req_t sfr_req = '0;
  logic   [7:0] sfr_rdata;
  logic   [7:0] iface_tx_data;
  logic         iface_tx_request, iface_tx_grant, iface_tx_valid, iface_rx_grant, fifo_irq, fifo_clk_en;
  hlf_rx_push_t iface_rx_request;
  int           failures = 0;
  int           checks = 0;

  hlf_fifo_mgr dut (.ref_clk(ref_clk), .rst_b(rst_b), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .iface_tx_request(iface_tx_request), .iface_tx_grant(iface_tx_grant), .iface_tx_valid(iface_tx_valid),
    .iface_tx_data(iface_tx_data), .iface_rx_request(iface_rx_request), .iface_rx_grant(iface_rx_grant),
    .fifo_irq(fifo_irq), .fifo_clk_en(fifo_clk_en));
  hlf_host_model host (.ref_clk(ref_clk), .drain(drain), .iface_tx_request(iface_tx_request),
    .iface_tx_grant(iface_tx_grant), .iface_tx_valid(iface_tx_valid), .iface_tx_data(iface_tx_data),
    .iface_rx_request(iface_rx_request), .iface_rx_grant(iface_rx_grant));

  // Clock of 40 ns period.
  always #20 ref_clk = ~ref_clk;

  // One register write strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    #1 sfr_req.wr = 1'b0;
  endtask

  // One register read, compared in its answer cycle.
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    #1 sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: sfr_req.wdata};
    @(posedge ref_clk);
    #1 sfr_req.rd = 1'b0;
    `CHK(sfr_rdata, e)
  endtask

  // Waits, bounded, until the host holds n transmit bytes.
  task automatic wait_got(input int n);
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      if (host.got_q.size() >= n)
        break;
    end
    `CHK(host.got_q.size() >= n, 1'b1)
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #100us;
    failures++;
    test_done();
  end

  // Directed sequence.
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    rc(HLF_ADDR_RX_THRESHOLD, 8'h00);
    rc(HLF_ADDR_TX_THRESHOLD, 8'h00);
    rc(HLF_ADDR_TX_FREE_SPACE, 8'h7F);
    rc(HLF_ADDR_RX_FILL_COUNT, 8'h00);
    rc(HLF_ADDR_QUEUE_STATUS, 8'h29);
    rc(HLF_ADDR_IRQ_SOURCE, 8'h00);
    rc(HLF_ADDR_RX_PARTITION_SIZE, 8'h80);
    rc(8'hA0, 8'h00);
    wr(HLF_ADDR_RX_THRESHOLD, 8'h5A);
    rc(HLF_ADDR_RX_THRESHOLD, 8'h5A);
    wr(HLF_ADDR_TX_THRESHOLD, 8'h01);
    rc(HLF_ADDR_TX_THRESHOLD, 8'h01);
    wr(HLF_ADDR_TX_FREE_SPACE, 8'h00);
    wr(HLF_ADDR_QUEUE_STATUS, 8'hFF);
    rc(HLF_ADDR_QUEUE_STATUS, 8'hA9);
    `CHK(fifo_clk_en, 1'b1)
    rc(HLF_ADDR_TX_FREE_SPACE, 8'h7F);
    wr(HLF_ADDR_DATA_PORT, 8'h11);
    wr(HLF_ADDR_DATA_PORT, 8'h22);
    rc(HLF_ADDR_TX_FREE_SPACE, 8'h7D);
    rc(HLF_ADDR_QUEUE_STATUS, 8'h81);
    drain = 1'b1;
    wait_got(2);
    drain = 1'b0;
    `CHK(host.got_q[0], 8'h11)
    `CHK(host.got_q[1], 8'h22)
    rc(HLF_ADDR_QUEUE_STATUS, 8'hA9);
    // Transmit part shrunk to two bytes, then overfilled.
    wr(HLF_ADDR_RX_PARTITION_SIZE, 8'hFD);
    wr(HLF_ADDR_DATA_PORT, 8'h33);
    wr(HLF_ADDR_DATA_PORT, 8'h44);
    wr(HLF_ADDR_DATA_PORT, 8'h55);
    rc(HLF_ADDR_TX_FREE_SPACE, 8'h00);
    rc(HLF_ADDR_QUEUE_STATUS, 8'h91);
    rc(HLF_ADDR_IRQ_SOURCE, 8'h38);
    drain = 1'b1;
    @(posedge ref_clk);
    #1 drain = 1'b0;
    wait_got(3);
    `CHK(host.got_q[2], 8'h33)
    rc(HLF_ADDR_QUEUE_STATUS, 8'hA1);
    wr(HLF_ADDR_IRQ_ENABLE_FLUSH, 8'h20);
    `CHK(fifo_irq, 1'b1)
    wr(HLF_ADDR_IRQ_SOURCE, 8'hA0);
    `CHK(fifo_irq, 1'b0)
    wr(HLF_ADDR_IRQ_ENABLE_FLUSH, 8'h80);
    wr(HLF_ADDR_IRQ_ENABLE_FLUSH, 8'h00);
    rc(HLF_ADDR_TX_FREE_SPACE, 8'h02);
    // Receive part shrunk to two bytes, then overrun.
    wr(HLF_ADDR_RX_PARTITION_SIZE, 8'h02);
    wr(HLF_ADDR_RX_THRESHOLD, 8'h02);
    wr(HLF_ADDR_IRQ_SOURCE, 8'hBF);
    host.send(8'hAA);
    host.send(8'hBB);
    host.send(8'hCC);
    rc(HLF_ADDR_RX_FILL_COUNT, 8'h02);
    rc(HLF_ADDR_QUEUE_STATUS, 8'hAE);
    rc(HLF_ADDR_IRQ_SOURCE, 8'h17);
    rc(HLF_ADDR_DATA_PORT, 8'hAA);
    rc(HLF_ADDR_QUEUE_STATUS, 8'hA8);
    rc(HLF_ADDR_DATA_PORT, 8'hBB);
    rc(HLF_ADDR_DATA_PORT, 8'h00);
    rc(HLF_ADDR_QUEUE_STATUS, 8'hA9);
    // CPU push and host push in the same cycle.
    fork
      host.send(8'hDD);
      wr(HLF_ADDR_DATA_PORT, 8'h77);
    join
    rc(HLF_ADDR_RX_FILL_COUNT, 8'h01);
    rc(HLF_ADDR_TX_FREE_SPACE, 8'hFC);
    drain = 1'b1;
    wait_got(4);
    drain = 1'b0;
    `CHK(host.got_q[3], 8'h77)
    wr(HLF_ADDR_IRQ_ENABLE_FLUSH, 8'h40);
    wr(HLF_ADDR_IRQ_ENABLE_FLUSH, 8'h00);
    rc(HLF_ADDR_RX_FILL_COUNT, 8'h00);
    test_done();
  end
endmodule

bind hlf_fifo_mgr hlf_fifo_mgr_asserts u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .iface_tx_request(iface_tx_request), .iface_tx_grant(iface_tx_grant),
  .iface_tx_valid(iface_tx_valid), .iface_tx_data(iface_tx_data), .iface_rx_request(iface_rx_request),
  .iface_rx_grant(iface_rx_grant), .fifo_irq(fifo_irq), .fifo_clk_en(fifo_clk_en));
